// ### design/rtsc_cfg.svh
// Purpose: Offsets, field positions, reset values and keys of the timestamp capture block
// Assumes: Byte addresses on an 8-bit register port, 32-bit data
// Notes:   Definitions only; types live in rtsc_pkg
`ifndef RTSC_CFG_SVH
`define RTSC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTSC_OFS_STATUS 8'h0C
`define RTSC_OFS_KEY 8'h24
`define RTSC_OFS_TS_TIME 8'h30
`define RTSC_OFS_TS_DATE 8'h34
`define RTSC_OFS_TS_SNAP_PRESCALER_COUNT 8'h38
`define RTSC_OFS_CAL 8'h3C
`define RTSC_OFS_CLEAR 8'h40
`define RTSC_OFS_IRQ_EN 8'h44

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTSC_SEC_ONES_LSB 0
`define RTSC_SEC_TENS_LSB 4
`define RTSC_MIN_ONES_LSB 8
`define RTSC_MIN_TENS_LSB 12
`define RTSC_HR_ONES_LSB 16
`define RTSC_HR_TENS_LSB 20
`define RTSC_MERIDIEM_BIT 22
`define RTSC_DAY_ONES_LSB 0
`define RTSC_DAY_TENS_LSB 4
`define RTSC_MON_ONES_LSB 8
`define RTSC_MON_TENS_BIT 12
`define RTSC_WEEKDAY_LSB 13
`define RTSC_KEY_LSB 0
`define RTSC_FLAG_BIT 0
`define RTSC_OVR_BIT 1

// ----------------------------------------
// Reset values, masks and keys
// ----------------------------------------
`define RTSC_SNAP_RST 32'h0000_0000
`define RTSC_SNAP_PRESCALER_COUNT_RST 16'h0000
`define RTSC_CAL_RST 32'h0000_0000
`define RTSC_STATUS_RST 2'h0
`define RTSC_KEY_READ 32'h0000_0000
`define RTSC_CAL_WMASK 32'hFFFF_E1FF
`define RTSC_KEY_FIRST 8'hCA
`define RTSC_KEY_SECOND 8'h53

`endif

// ### design/rtsc_pkg.sv
// Purpose: Types shared by the timestamp capture block
// Assumes: Constants come from rtsc_cfg.svh
// Notes:   Protection states are Gray coded along the unlock path
package rtsc_pkg;

    // ----------------------------------------
    // Write protection states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        RTSC_LOCKED = 2'b00,
        RTSC_HALF = 2'b01,
        RTSC_OPEN = 2'b11
    } rtsc_prot_state_t;

endpackage : rtsc_pkg

// ### design/rtsc_sync.sv
// Purpose: Three-stage synchroniser and rising-edge detect for the stamp pin
// Assumes: Pin is asynchronous to i_mclk
// Notes:   A change counts only when stages two and three agree
`include "rtsc_cfg.svh"
module rtsc_sync
    import rtsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_rise
);
    logic meta_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    wire agree = (stage2_reg == stage3_reg);

    // Edge only after two stable samples, so a glitch cannot stamp twice
    assign o_rise = agree && stage2_reg && !level_reg;

    // Chain and filtered level
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            meta_reg <= i_async;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
            level_reg <= agree ? stage2_reg : level_reg;
        end
    end

endmodule : rtsc_sync

// ### design/rtsc_protect.sv
// Purpose: Key sequence that unlocks the protected calibration register
// Assumes: Key writes are one-cycle strobes from the register port
// Notes:   Any wrong key relocks; system reset relocks
`include "rtsc_cfg.svh"
module rtsc_protect
    import rtsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_sys_resetn,
    input wire logic i_key_wr,
    input wire logic [7:0] i_key,
    output logic o_unlocked
);
    rtsc_prot_state_t state_reg;
    rtsc_prot_state_t state_next;

    // Next state of the key sequence
    always_comb
    begin
        state_next = state_reg;
        if (!i_sys_resetn)
            state_next = RTSC_LOCKED;
        else if (i_key_wr)
        begin
            case (state_reg)
                RTSC_HALF: state_next = (i_key == `RTSC_KEY_SECOND) ? RTSC_OPEN : RTSC_LOCKED;
                default: state_next = (i_key == `RTSC_KEY_FIRST) ? RTSC_HALF : RTSC_LOCKED;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            state_reg <= RTSC_LOCKED;
        else if (i_ce)
            state_reg <= state_next;
    end

    assign o_unlocked = (state_reg == RTSC_OPEN);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence seq_first_key;
        i_ce && i_sys_resetn && i_key_wr && (i_key == `RTSC_KEY_FIRST);
    endsequence

    sequence seq_second_key;
        i_ce && i_sys_resetn && i_key_wr && (i_key == `RTSC_KEY_SECOND);
    endsequence

    // Keyed on state, so idle cycles or other writes between the keys are covered
    AST_UNLOCK_SEQUENCE: assert property ((state_reg == RTSC_HALF) ##0 seq_second_key
        |=> o_unlocked)
        else $error("Key pair did not unlock");

    AST_FIRST_KEY_ARMS: assert property ((state_reg != RTSC_HALF) ##0 seq_first_key
        |=> state_reg == RTSC_HALF)
        else $error("First key did not arm");

    AST_WRONG_KEY_LOCKS: assert property (i_ce && i_key_wr && (i_key != `RTSC_KEY_FIRST)
        && (i_key != `RTSC_KEY_SECOND) |=> !o_unlocked)
        else $error("Wrong key left protection open");

endmodule : rtsc_protect

// ### design/rtsc_timestamp_capture.sv
// Purpose: Timestamp snapshot of calendar time, date and prescaler count
// Assumes: Live calendar fields come from logic on i_mclk; stamp pin is asynchronous
// Notes:   i_resetn is power-on reset; i_sys_resetn keeps snapshots and calibration
`include "rtsc_cfg.svh"
module rtsc_timestamp_capture
    import rtsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_sys_resetn,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_stamp_pin,
    input wire logic [3:0] i_live_sec_ones,
    input wire logic [2:0] i_live_sec_tens,
    input wire logic [3:0] i_live_min_ones,
    input wire logic [2:0] i_live_min_tens,
    input wire logic [3:0] i_live_hr_ones,
    input wire logic [1:0] i_live_hr_tens,
    input wire logic i_live_meridiem,
    input wire logic [3:0] i_live_day_ones,
    input wire logic [1:0] i_live_day_tens,
    input wire logic [3:0] i_live_mon_ones,
    input wire logic i_live_mon_tens,
    input wire logic [2:0] i_live_weekday,
    input wire logic [15:0] i_live_prescaler,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_stamp_flag
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [31:0] ts_time_reg;
    logic [31:0] ts_time_next;
    logic [31:0] ts_date_reg;
    logic [31:0] ts_date_next;
    logic [15:0] ts_snap_prescaler_count_reg;
    logic [15:0] ts_snap_prescaler_count_next;
    logic [31:0] cal_reg;
    logic [31:0] cal_next;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] irq_en_reg;
    logic [1:0] irq_en_next;
    logic irq_reg;
    logic irq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] time_cap;
    logic [31:0] date_cap;
    logic stamp_rise;
    logic unlocked;

    // Address match, shared by every decode below
    function automatic logic rtsc_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : rtsc_hit

    // ----------------------------------------
    // Stamp pin and write protection
    // ----------------------------------------
    rtsc_sync u_sync
    (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_stamp_pin),
        .o_rise(stamp_rise)
    );

    wire wr_key = i_wr && rtsc_hit(i_addr, `RTSC_OFS_KEY);

    rtsc_protect u_protect
    (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_sys_resetn(i_sys_resetn),
        .i_key_wr(wr_key),
        .i_key(i_wdata[`RTSC_KEY_LSB +: 8]),
        .o_unlocked(unlocked)
    );

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire stamp_evt = i_ce && stamp_rise;
    wire wr_cal = i_wr && rtsc_hit(i_addr, `RTSC_OFS_CAL);
    wire wr_clear = i_wr && rtsc_hit(i_addr, `RTSC_OFS_CLEAR);
    wire wr_irq_en = i_wr && rtsc_hit(i_addr, `RTSC_OFS_IRQ_EN);
    wire [1:0] clear_bits = wr_clear ? i_wdata[1:0] : 2'h0;
    wire flag_now = status_reg[`RTSC_FLAG_BIT];

    // ----------------------------------------
    // Live calendar packed into snapshot layout
    // ----------------------------------------
    always_comb
    begin
        time_cap = `RTSC_SNAP_RST;
        time_cap[`RTSC_SEC_ONES_LSB +: 4] = i_live_sec_ones;
        time_cap[`RTSC_SEC_TENS_LSB +: 3] = i_live_sec_tens;
        time_cap[`RTSC_MIN_ONES_LSB +: 4] = i_live_min_ones;
        time_cap[`RTSC_MIN_TENS_LSB +: 3] = i_live_min_tens;
        time_cap[`RTSC_HR_ONES_LSB +: 4] = i_live_hr_ones;
        time_cap[`RTSC_HR_TENS_LSB +: 2] = i_live_hr_tens;
        time_cap[`RTSC_MERIDIEM_BIT] = i_live_meridiem;
    end

    // Reserved date bits stay zero
    always_comb
    begin
        date_cap = `RTSC_SNAP_RST;
        date_cap[`RTSC_DAY_ONES_LSB +: 4] = i_live_day_ones;
        date_cap[`RTSC_DAY_TENS_LSB +: 2] = i_live_day_tens;
        date_cap[`RTSC_MON_ONES_LSB +: 4] = i_live_mon_ones;
        date_cap[`RTSC_MON_TENS_BIT] = i_live_mon_tens;
        date_cap[`RTSC_WEEKDAY_LSB +: 3] = i_live_weekday;
    end

    // ----------------------------------------
    // Status: stamp flag and overrun
    // ----------------------------------------
    // Set beats clear, so an event racing the clear is never lost
    wire [1:0] status_set = {stamp_evt && flag_now, stamp_evt};
    assign status_next = status_set | (status_reg & ~clear_bits);
    wire flag_drop = flag_now && !status_next[`RTSC_FLAG_BIT];

    // ----------------------------------------
    // Snapshot next values
    // ----------------------------------------
    // A new event overwrites an unread stamp; overrun tells software so
    assign ts_time_next = stamp_evt ? time_cap :
        (flag_drop ? `RTSC_SNAP_RST : ts_time_reg);
    assign ts_date_next = stamp_evt ? date_cap :
        (flag_drop ? `RTSC_SNAP_RST : ts_date_reg);
    assign ts_snap_prescaler_count_next = stamp_evt ? i_live_prescaler :
        (flag_drop ? `RTSC_SNAP_PRESCALER_COUNT_RST : ts_snap_prescaler_count_reg);

    // ----------------------------------------
    // Calibration and interrupt enable
    // ----------------------------------------
    // Locked writes are dropped silently; reserved bits never store
    assign cal_next = (wr_cal && unlocked) ? (i_wdata & `RTSC_CAL_WMASK) : cal_reg;
    assign irq_en_next = !i_sys_resetn ? 2'h0 : (wr_irq_en ? i_wdata[1:0] : irq_en_reg);
    // Uses next values so the output lines up with the status register
    assign irq_next = |(status_next & irq_en_next);

    // ----------------------------------------
    // Read mux, data valid only the cycle after the strobe
    // ----------------------------------------
    wire [31:0] rd_mux =
        rtsc_hit(i_addr, `RTSC_OFS_TS_TIME) ? ts_time_reg :
        rtsc_hit(i_addr, `RTSC_OFS_TS_DATE) ? ts_date_reg :
        rtsc_hit(i_addr, `RTSC_OFS_TS_SNAP_PRESCALER_COUNT) ? {16'h0000, ts_snap_prescaler_count_reg} :
        rtsc_hit(i_addr, `RTSC_OFS_CAL) ? cal_reg :
        rtsc_hit(i_addr, `RTSC_OFS_STATUS) ? {30'h0000_0000, status_reg} :
        rtsc_hit(i_addr, `RTSC_OFS_IRQ_EN) ? {30'h0000_0000, irq_en_reg} :
        `RTSC_KEY_READ;
    assign rdata_next = i_rd ? rd_mux : 32'h0000_0000;

    // ----------------------------------------
    // Power-on domain: snapshots and calibration
    // ----------------------------------------
    // System reset is not wired here, so contents survive it
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ts_time_reg <= `RTSC_SNAP_RST;
            ts_date_reg <= `RTSC_SNAP_RST;
            ts_snap_prescaler_count_reg <= `RTSC_SNAP_PRESCALER_COUNT_RST;
            cal_reg <= `RTSC_CAL_RST;
        end
        else if (i_ce)
        begin
            ts_time_reg <= ts_time_next;
            ts_date_reg <= ts_date_next;
            ts_snap_prescaler_count_reg <= ts_snap_prescaler_count_next;
            cal_reg <= cal_next;
        end
    end

    // ----------------------------------------
    // Status, interrupt and read port
    // ----------------------------------------
    // Flag lives with the snapshots so a system reset cannot orphan them
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            status_reg <= `RTSC_STATUS_RST;
            irq_en_reg <= 2'h0;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            status_reg <= status_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq = irq_reg;
    assign o_stamp_flag = status_reg[`RTSC_FLAG_BIT];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence seq_stamp;
        stamp_evt;
    endsequence

    sequence seq_flag_cleared;
        i_ce && flag_now && wr_clear && i_wdata[`RTSC_FLAG_BIT] && !stamp_evt;
    endsequence

    AST_SEC_CAPTURE: assert property (seq_stamp |=>
        ts_time_reg[`RTSC_SEC_ONES_LSB +: 4] == $past(i_live_sec_ones)
        && ts_time_reg[`RTSC_SEC_TENS_LSB +: 3] == $past(i_live_sec_tens))
        else $error("Seconds snapshot wrong");

    AST_MIN_CAPTURE: assert property (seq_stamp |=>
        ts_time_reg[`RTSC_MIN_ONES_LSB +: 4] == $past(i_live_min_ones)
        && ts_time_reg[`RTSC_MIN_TENS_LSB +: 3] == $past(i_live_min_tens))
        else $error("Minutes snapshot wrong");

    AST_HR_CAPTURE: assert property (seq_stamp |=>
        ts_time_reg[`RTSC_HR_ONES_LSB +: 4] == $past(i_live_hr_ones)
        && ts_time_reg[`RTSC_HR_TENS_LSB +: 2] == $past(i_live_hr_tens))
        else $error("Hours snapshot wrong");

    AST_MERIDIEM_CAPTURE: assert property (seq_stamp |=>
        ts_time_reg[`RTSC_MERIDIEM_BIT] == $past(i_live_meridiem))
        else $error("Meridiem snapshot wrong");

    AST_DAY_CAPTURE: assert property (seq_stamp |=>
        ts_date_reg[`RTSC_DAY_ONES_LSB +: 4] == $past(i_live_day_ones)
        && ts_date_reg[`RTSC_DAY_TENS_LSB +: 2] == $past(i_live_day_tens))
        else $error("Day snapshot wrong");

    AST_MONTH_CAPTURE: assert property (seq_stamp |=>
        ts_date_reg[`RTSC_MON_ONES_LSB +: 4] == $past(i_live_mon_ones)
        && ts_date_reg[`RTSC_MON_TENS_BIT] == $past(i_live_mon_tens))
        else $error("Month snapshot wrong");

    AST_WEEKDAY_CAPTURE: assert property (seq_stamp |=>
        ts_date_reg[`RTSC_WEEKDAY_LSB +: 3] == $past(i_live_weekday))
        else $error("Weekday snapshot wrong");

    AST_SNAP_PRESCALER_COUNT_CAPTURE: assert property (seq_stamp |=>
        ts_snap_prescaler_count_reg == $past(i_live_prescaler))
        else $error("Prescaler snapshot wrong");

    AST_FLAG_WITH_CAPTURE: assert property (seq_stamp |=>
        o_stamp_flag && ts_time_reg == $past(time_cap))
        else $error("Flag and snapshot not in the same cycle");

    AST_CLEAR_EMPTIES: assert property (seq_flag_cleared |=>
        !o_stamp_flag && ts_time_reg == `RTSC_SNAP_RST
        && ts_snap_prescaler_count_reg == `RTSC_SNAP_PRESCALER_COUNT_RST)
        else $error("Snapshot survived flag clear");

    AST_DATE_ZERO_NO_FLAG: assert property (!o_stamp_flag |->
        ts_date_reg == `RTSC_SNAP_RST)
        else $error("Date readable without flag");

    AST_SET_BEATS_CLEAR: assert property (stamp_evt && wr_clear
        && i_wdata[`RTSC_FLAG_BIT] |=> o_stamp_flag)
        else $error("Event lost against clear");

    AST_CAL_LOCKED: assert property (i_ce && wr_cal && !unlocked |=>
        $stable(cal_reg))
        else $error("Locked calibration write taken");

    AST_KEY_READS_ZERO: assert property (i_ce && i_rd && rtsc_hit(i_addr, `RTSC_OFS_KEY)
        |=> o_rdata == `RTSC_KEY_READ)
        else $error("Key field read not zero");

    AST_IRQ_LEVEL: assert property (o_irq == |(status_reg & irq_en_reg))
        else $error("Interrupt level mismatch");

    // ----------------------------------------
    // Read-only, system reset, date clear and overrun checks
    // ----------------------------------------
    // An event in the same cycle legally reloads, so it is left out
    sequence seq_time_write;
        i_ce && i_wr && rtsc_hit(i_addr, `RTSC_OFS_TS_TIME) && !stamp_evt;
    endsequence

    sequence seq_date_write;
        i_ce && i_wr && rtsc_hit(i_addr, `RTSC_OFS_TS_DATE) && !stamp_evt;
    endsequence

    sequence seq_snap_prescaler_count_write;
        i_ce && i_wr && rtsc_hit(i_addr, `RTSC_OFS_TS_SNAP_PRESCALER_COUNT) && !stamp_evt;
    endsequence

    // Quiet system reset: no write, no event, so snapshots, calibration and status may not move
    sequence seq_sys_reset_quiet;
        i_ce && !i_sys_resetn && !i_wr && !stamp_evt;
    endsequence

    // Second event before software clears the first
    sequence seq_overrun;
        stamp_evt && flag_now;
    endsequence

    AST_TIME_READ_ONLY: assert property (seq_time_write |=> $stable(ts_time_reg))
        else $error("Time snapshot took a write");

    AST_DATE_READ_ONLY: assert property (seq_date_write |=> $stable(ts_date_reg))
        else $error("Date snapshot took a write");

    AST_SNAP_PRESCALER_COUNT_READ_ONLY: assert property (seq_snap_prescaler_count_write |=>
        $stable(ts_snap_prescaler_count_reg))
        else $error("Subsecond snapshot took a write");

    AST_SYS_RESET_KEEPS: assert property (seq_sys_reset_quiet |=>
        $stable(ts_time_reg) && $stable(ts_date_reg) && $stable(ts_snap_prescaler_count_reg)
        && $stable(cal_reg) && $stable(status_reg))
        else $error("System reset disturbed stored state");

    AST_DATE_CLEAR: assert property (seq_flag_cleared |=>
        ts_date_reg == `RTSC_SNAP_RST)
        else $error("Date survived flag clear");

    AST_OVERRUN_SET: assert property (seq_overrun |=>
        o_stamp_flag && status_reg[`RTSC_OVR_BIT])
        else $error("Second event did not mark overrun");

endmodule : rtsc_timestamp_capture

// ### testbench/rtc_timestamp_capture_tb_top.sv
// Purpose: Self-checking bench for the timestamp capture block
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Clock enable is low during the initial power-on reset and for one write in t_race_freeze; the stamp pin is driven synchronously
`include "rtsc_cfg.svh"
module rtc_timestamp_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------
    logic mclk, resetn, sys_resetn, ce, wr, rd, pin, irq, flag;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, live_t, live_d;
    logic [15:0] live_p, exp_p;
    int bad_count, total_checks;

    // Live calendar ports unpacked from register-shaped words
    rtsc_timestamp_capture uut (.i_mclk(mclk), .i_resetn(resetn), .i_sys_resetn(sys_resetn),
        .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_stamp_pin(pin),
        .i_live_sec_ones(live_t[3:0]), .i_live_sec_tens(live_t[6:4]),
        .i_live_min_ones(live_t[11:8]), .i_live_min_tens(live_t[14:12]),
        .i_live_hr_ones(live_t[19:16]), .i_live_hr_tens(live_t[21:20]),
        .i_live_meridiem(live_t[22]), .i_live_day_ones(live_d[3:0]),
        .i_live_day_tens(live_d[5:4]), .i_live_mon_ones(live_d[11:8]),
        .i_live_mon_tens(live_d[12]), .i_live_weekday(live_d[15:13]),
        .i_live_prescaler(live_p), .o_rdata(rdata), .o_irq(irq), .o_stamp_flag(flag));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data is looked at only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, e, what);
    endtask : rd_chk

    // Pin rise; while the flag was clear the prescaler moves every cycle so the capture cycle is visible
    task automatic stamp(input logic [31:0] t, input logic [31:0] d);
        int n;
        logic was;
        @(posedge mclk);
        was = flag;
        live_t <= t;
        live_d <= d;
        pin <= 1'b1;
        exp_p = live_p;
        for (n = 1; n <= 8; n++)
        begin
            @(posedge mclk);
            if (!was)
                live_p <= live_p + 16'h0101;
            #1;
            if (!was && flag === 1'b1)
                break;
        end
        if (!was)
        begin
            exp_p = live_p - 16'h0101;
            chk(32'(n <= 8), 32'h0000_0001, "stamp flag rise");
        end
        @(posedge mclk);
        pin <= 1'b0;
        live_t <= ~t & 32'h007F_7F7F;
        live_d <= ~d & 32'h0000_FF3F;
        repeat (3) @(posedge mclk);
    endtask : stamp

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        logic [7:0] ofs [8] = '{8'h0C, 8'h24, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h44, 8'h50};
        foreach (ofs[i])
            rd_chk(ofs[i], 32'h0000_0000, "reset value");
        chk({31'h0, flag}, 32'h0000_0000, "flag after reset");
    endtask : t_reset_values

    // Every weekday code, varied BCD fields, hold, read-only, clear
    task automatic t_capture_loop();
        logic [31:0] t, d;
        for (int k = 0; k < 8; k++)
        begin
            t = {9'h0, 1'(k), 2'(k % 3), 4'(k), 1'b0, 3'(k % 6), 4'(9 - k), 1'b0, 3'(5 - k % 6),
                4'(k + 1)};
            d = {16'h0, 3'(k), 1'(k % 2), 4'(9 - k), 2'h0, 2'(k % 4), 4'(k + 2)};
            stamp(t, d);
            rd_chk(`RTSC_OFS_TS_TIME, t, "time snapshot");
            rd_chk(`RTSC_OFS_TS_DATE, d, "date snapshot");
            rd_chk(`RTSC_OFS_TS_SNAP_PRESCALER_COUNT, {16'h0, exp_p}, "subsecond snapshot");
            rd_chk(`RTSC_OFS_STATUS, 32'h0000_0001, "status after stamp");
            wr_reg(`RTSC_OFS_TS_TIME, 32'hFFFF_FFFF);
            wr_reg(`RTSC_OFS_TS_DATE, 32'hFFFF_FFFF);
            wr_reg(`RTSC_OFS_TS_SNAP_PRESCALER_COUNT, 32'hFFFF_FFFF);
            rd_chk(`RTSC_OFS_TS_TIME, t, "time after write");
            rd_chk(`RTSC_OFS_TS_DATE, d, "date after write");
            rd_chk(`RTSC_OFS_TS_SNAP_PRESCALER_COUNT, {16'h0, exp_p}, "subsecond after write");
            wr_reg(`RTSC_OFS_CLEAR, 32'h0000_0001);
            #1;
            chk({31'h0, flag}, 32'h0000_0000, "flag after clear");
            rd_chk(`RTSC_OFS_TS_TIME, 32'h0000_0000, "time after clear");
            rd_chk(`RTSC_OFS_TS_DATE, 32'h0000_0000, "date after clear");
            rd_chk(`RTSC_OFS_TS_SNAP_PRESCALER_COUNT, 32'h0000_0000, "subsecond after clear");
        end
    endtask : t_capture_loop

    // Masked and enabled interrupt; a second event overruns, then both status bits are cleared
    task automatic t_irq_overrun();
        stamp(32'h0012_3456, 32'h0000_2531);
        chk({31'h0, irq}, 32'h0000_0000, "irq masked");
        wr_reg(`RTSC_OFS_IRQ_EN, 32'h0000_0001);
        #1;
        chk({31'h0, irq}, 32'h0000_0001, "irq enabled");
        rd_chk(`RTSC_OFS_IRQ_EN, 32'h0000_0001, "irq enable readback");
        stamp(32'h0041_0759, 32'h0000_F129);
        rd_chk(`RTSC_OFS_STATUS, 32'h0000_0003, "overrun status");
        rd_chk(`RTSC_OFS_TS_TIME, 32'h0041_0759, "latest time kept");
        rd_chk(`RTSC_OFS_TS_DATE, 32'h0000_F129, "latest date kept");
        wr_reg(`RTSC_OFS_CLEAR, 32'h0000_0003);
        #1;
        chk({30'h0, irq, flag}, 32'h0000_0000, "irq and flag cleared");
        rd_chk(`RTSC_OFS_TS_DATE, 32'h0000_0000, "date cleared");
        wr_reg(`RTSC_OFS_IRQ_EN, 32'h0000_0000);
    endtask : t_irq_overrun

    // Key sequence, relock, system reset keeps contents, power-on reset clears
    task automatic t_protect_resets();
        wr_reg(`RTSC_OFS_CAL, 32'hFFFF_FFFF);
        rd_chk(`RTSC_OFS_CAL, 32'h0000_0000, "locked cal write");
        wr_reg(`RTSC_OFS_KEY, {24'h0, `RTSC_KEY_FIRST});
        wr_reg(`RTSC_OFS_KEY, {24'h0, `RTSC_KEY_SECOND});
        rd_chk(`RTSC_OFS_KEY, 32'h0000_0000, "key reads zero");
        wr_reg(`RTSC_OFS_CAL, 32'hFFFF_FFFF);
        rd_chk(`RTSC_OFS_CAL, `RTSC_CAL_WMASK, "unlocked cal write");
        wr_reg(`RTSC_OFS_KEY, 32'h0000_0011);
        wr_reg(`RTSC_OFS_CAL, 32'h0000_0000);
        rd_chk(`RTSC_OFS_CAL, `RTSC_CAL_WMASK, "wrong key relocks");
        stamp(32'h0023_5959, 32'h0000_3231);
        wr_reg(`RTSC_OFS_IRQ_EN, 32'h0000_0001);
        @(posedge mclk);
        sys_resetn <= 1'b0;
        @(posedge mclk);
        sys_resetn <= 1'b1;
        #1;
        chk({30'h0, irq, flag}, 32'h0000_0001, "flag kept, irq off by system reset");
        rd_chk(`RTSC_OFS_TS_TIME, 32'h0023_5959, "time kept by system reset");
        rd_chk(`RTSC_OFS_CAL, `RTSC_CAL_WMASK, "cal kept by system reset");
        rd_chk(`RTSC_OFS_IRQ_EN, 32'h0000_0000, "irq enable after system reset");
        wr_reg(`RTSC_OFS_KEY, {24'h0, `RTSC_KEY_FIRST});
        wr_reg(`RTSC_OFS_KEY, {24'h0, `RTSC_KEY_SECOND});
        wr_reg(`RTSC_OFS_CAL, 32'h0000_1234);
        rd_chk(`RTSC_OFS_CAL, 32'h0000_0034, "cal write mask");
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(`RTSC_OFS_CAL, 32'h0000_0000, "cal after power-on");
        rd_chk(`RTSC_OFS_TS_TIME, 32'h0000_0000, "time after power-on");
        rd_chk(`RTSC_OFS_TS_SNAP_PRESCALER_COUNT, 32'h0000_0000, "subsecond after power-on");
        chk({31'h0, flag}, 32'h0000_0000, "flag after power-on");
    endtask : t_protect_resets

    // Event and clear in one cycle keep the flag; a low clock enable drops writes
    task automatic t_race_freeze();
        @(posedge mclk);
        pin <= 1'b1;
        repeat (2) @(posedge mclk);
        wr_reg(`RTSC_OFS_CLEAR, 32'h0000_0001);
        #1;
        chk({31'h0, flag}, 32'h0000_0001, "set beats clear");
        rd_chk(`RTSC_OFS_STATUS, 32'h0000_0001, "no overrun from race");
        @(posedge mclk);
        pin <= 1'b0;
        ce <= 1'b0;
        wr_reg(`RTSC_OFS_CLEAR, 32'h0000_0001);
        ce <= 1'b1;
        #1;
        chk({31'h0, flag}, 32'h0000_0001, "frozen by clock enable");
        wr_reg(`RTSC_OFS_CLEAR, 32'h0000_0001);
        #1;
        chk({31'h0, flag}, 32'h0000_0000, "flag after race clear");
    endtask : t_race_freeze

    // ----------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------
    task automatic results();
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // Whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        #200000;
        bad_count++;
        results();
    end

    initial
    begin
        {resetn, sys_resetn, ce, wr, rd, pin} = 6'b010000;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        live_t = 32'h0000_0000;
        live_d = 32'h0000_0000;
        live_p = 16'h0000;
        bad_count = 0;
        total_checks = 0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        ce <= 1'b1;
        t_reset_values();
        t_capture_loop();
        t_irq_overrun();
        t_race_freeze();
        t_protect_resets();
        results();
    end

endmodule : rtc_timestamp_capture_tb_top
